//--- hdl/card_seq_map.svh
// Offsets-free map: timing counts and bit positions for the card sequencer.
// Assumes a 125 MHz clock; included by the sequencer and the repeater.
`ifndef CARD_SEQ_MAP_SVH
`define CARD_SEQ_MAP_SVH
`define CLK_PERIOD_PS 8000
`define SEQ_INTERVAL_US 25
`define SEQ_SUBTICKS 64
`define SUBTICK_CYCLES (`SEQ_INTERVAL_US * 1000000 / `SEQ_SUBTICKS / `CLK_PERIOD_PS)
`define RST_LOW_SUB 1
`define CLK_STOP_SUB 32
`define IO_LOW_SUB 64
`define VCC_RAMP_SUB 96
`define GROUND_SUB 320
`define REP_DELAY_NS 200
`define REP_DELAY_CYCLES (`REP_DELAY_NS * 1000 / `CLK_PERIOD_PS)
`define CTRL_POWER_BIT 0
`endif

//--- hdl/card_seq_pkg.sv
// Types shared by the card sequencer and its repeaters.
// Assumes the map header is compiled alongside.
package card_seq_pkg;
	typedef enum logic [2:0] {
		ST_OFF, ST_ACTIVE, ST_WAIT_RST, ST_DEACT
	} seq_state_t;
	typedef enum logic [1:0] {
		REP_IDLE, REP_HOST_MASTER, REP_CARD_MASTER, REP_RELEASE
	} rep_state_t;
endpackage

//--- hdl/aux_repeater.sv
// Pseudo-bidirectional repeater between one controller port and one card contact.
// Assumes pull-ups outside hold both wires high while nobody drives them.
`timescale 1ns/1ps
`include "card_seq_map.svh"
module aux_repeater
	import card_seq_pkg::*;
#(
	parameter int DELAY_CYCLES = `REP_DELAY_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic host_in,
	output logic host_out,
	output logic host_oe_n,
	input wire logic card_in,
	output logic card_out,
	output logic card_oe_n
);
	initial begin
		if (DELAY_CYCLES < 1 || DELAY_CYCLES > 255) $error("aux_repeater: bad delay");
	end
	rep_state_t state;
	logic [7:0] count;
	logic host_q;
	logic card_q;
	logic pulled;
	wire host_fall = host_q && !host_in;
	wire card_fall = card_q && !card_in;
	wire delay_done = count == 8'(DELAY_CYCLES);
	// Master side input, with the slave side ignored once a master is chosen
	wire master_in = (state == REP_HOST_MASTER) ? host_in : card_in;
	always_ff @(posedge clk) begin
		if (reset) begin
			state <= REP_IDLE;
			count <= 8'h00;
			host_q <= 1'b1;
			card_q <= 1'b1;
			pulled <= 1'b0;
			host_out <= 1'b1;
			host_oe_n <= 1'b1;
			card_out <= 1'b1;
			card_oe_n <= 1'b1;
		end else begin
			host_q <= host_in;
			card_q <= card_in;
			case (state)
				REP_IDLE: begin
					count <= 8'h00;
					pulled <= 1'b0;
					// Host wins a tie so the outcome is defined
					if (host_fall) begin
						state <= REP_HOST_MASTER;
					end else if (card_fall) begin
						state <= REP_CARD_MASTER;
					end
				end
				REP_HOST_MASTER, REP_CARD_MASTER: begin
					if (!pulled && !delay_done) begin
						count <= count + 8'h01;
					end
					if (!pulled && delay_done) begin
						pulled <= 1'b1;
						count <= 8'h00;
						if (state == REP_HOST_MASTER) begin
							card_out <= 1'b0;
							card_oe_n <= 1'b0;
						end else begin
							host_out <= 1'b0;
							host_oe_n <= 1'b0;
						end
					end
					if (pulled && master_in) begin
						// Push the slave high briefly to beat the slow pull-up
						card_out <= 1'b1;
						host_out <= 1'b1;
						count <= 8'h00;
						state <= REP_RELEASE;
					end
				end
				REP_RELEASE: begin
					count <= count + 8'h01;
					if (delay_done) begin
						host_oe_n <= 1'b1;
						card_oe_n <= 1'b1;
						count <= 8'h00;
						state <= REP_IDLE;
					end
				end
				default: state <= REP_IDLE;
			endcase
		end
	end
	// Cycles spent as host master before the card side is pulled; held once pulled
	logic [8:0] lead_count;
	always_ff @(posedge clk) begin
		if (reset || state != REP_HOST_MASTER) begin
			lead_count <= 9'h000;
		end else if (!pulled) begin
			lead_count <= lead_count + 9'h001;
		end
	end
	chk_slave_low_delay: assert property (@(posedge clk) disable iff (reset)
		state == REP_HOST_MASTER |->
		(card_oe_n == (lead_count <= 9'(DELAY_CYCLES))) && (card_oe_n || !card_out))
		else $error("slave pull-down not on time");
	chk_one_side_drives: assert property (@(posedge clk) disable iff (reset)
		!(!host_oe_n && !card_oe_n)) else $error("both repeater sides driven");
	chk_idle_released: assert property (@(posedge clk) disable iff (reset)
		state == REP_IDLE |-> ##1 (host_oe_n && card_oe_n)) else $error("idle side still driven");
	chk_release_high: assert property (@(posedge clk) disable iff (reset)
		$rose(state == REP_RELEASE) |-> (card_out && host_out) ##[1:300] state == REP_IDLE)
		else $error("release phase wrong");
	cov_card_master: cover property (@(posedge clk) disable iff (reset) $rose(state == REP_CARD_MASTER));
endmodule

//--- hdl/card_deactivation_sequencer.sv
// Card contact sequencer: deactivation on command or fault, card-ok flag, aux repeaters.
// Assumes synchronous inputs; analog supply and converter act on the level outputs.
`timescale 1ns/1ps
`include "card_seq_map.svh"
module card_deactivation_sequencer
	import card_seq_pkg::*;
#(
	parameter int SUBTICK_CYCLES = `SUBTICK_CYCLES,
	parameter int REP_DELAY_CYCLES = `REP_DELAY_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [3:0] output_extension_register,
	input wire logic card_present,
	input wire logic fault_overcurrent,
	input wire logic fault_short,
	input wire logic status_read,
	output logic card_rst,
	output logic card_clk_en,
	output logic card_io_en,
	output logic vcc_on,
	output logic vcc_ramp_down,
	output logic converter_on,
	output logic contacts_grounded,
	output logic card_ok,
	output logic presence_change_flag,
	output logic fault_irq,
	output logic seq_busy,
	input wire logic aux_port_a_in,
	output logic aux_port_a_out,
	output logic aux_port_a_oe_n,
	input wire logic aux_port_b_in,
	output logic aux_port_b_out,
	output logic aux_port_b_oe_n,
	input wire logic [1:0] aux_card_in,
	output logic [1:0] aux_card_out,
	output logic [1:0] aux_card_oe_n
);
	initial begin
		if (SUBTICK_CYCLES < 1 || SUBTICK_CYCLES > 65535) $error("sequencer: bad subtick");
	end
	seq_state_t state;
	logic [15:0] div;
	logic [8:0] sub;
	logic cmd_q;
	logic removed;
	logic fault_pending;
	logic card_ok_q;
	wire power_cmd = output_extension_register[`CTRL_POWER_BIT];
	wire subtick = div == 16'(SUBTICK_CYCLES - 1);
	wire cmd_fall = cmd_q && !power_cmd;
	wire removal = !card_present && state == ST_ACTIVE;
	wire fault_now = (fault_overcurrent || fault_short || removal) && state == ST_ACTIVE;
	wire at_rst = sub == 9'(`RST_LOW_SUB);
	// Grounding is timed from the reset step, not from the command edge
	wire at_ground = sub == 9'(`RST_LOW_SUB + `GROUND_SUB);
	// Flag recovers only when sequence is done, command is low and a card is seated
	wire next_card_ok = !card_present ? 1'b0 :
		fault_pending ? (state == ST_OFF && !power_cmd) : 1'b1;
	always_ff @(posedge clk) begin
		if (reset) begin
			div <= 16'h0000;
		end else begin
			div <= subtick ? 16'h0000 : div + 16'h0001;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			state <= ST_OFF;
			sub <= 9'h000;
			cmd_q <= 1'b0;
			removed <= 1'b0;
			fault_pending <= 1'b0;
			card_rst <= 1'b0;
			card_clk_en <= 1'b0;
			card_io_en <= 1'b0;
			vcc_on <= 1'b0;
			vcc_ramp_down <= 1'b0;
			converter_on <= 1'b0;
			contacts_grounded <= 1'b1;
			fault_irq <= 1'b0;
			seq_busy <= 1'b0;
		end else begin
			cmd_q <= power_cmd;
			fault_irq <= fault_now;
			case (state)
				ST_OFF: begin
					removed <= 1'b0;
					if (!power_cmd) begin
						fault_pending <= fault_pending && !card_present;
					end
					// Activation is not sequenced; converter, supply, reset, clock and I/O all switch on in one cycle
					if (power_cmd && !cmd_q && card_present && !fault_pending) begin
						state <= ST_ACTIVE;
						converter_on <= 1'b1;
						vcc_on <= 1'b1;
						contacts_grounded <= 1'b0;
						card_rst <= 1'b1;
						card_clk_en <= 1'b1;
						card_io_en <= 1'b1;
					end
				end
				ST_ACTIVE: begin
					if (cmd_fall || fault_now) begin
						state <= ST_WAIT_RST;
						sub <= 9'h000;
						seq_busy <= 1'b1;
						fault_pending <= fault_now;
						removed <= removal;
					end
				end
				ST_WAIT_RST, ST_DEACT: begin
					if (subtick) begin
						sub <= sub + 9'h001;
					end
					if (at_rst) begin
						card_rst <= 1'b0;
						state <= ST_DEACT;
					end
					if (sub == 9'(`RST_LOW_SUB + `CLK_STOP_SUB)) begin
						card_clk_en <= 1'b0;
					end
					if (sub == 9'(`RST_LOW_SUB + `IO_LOW_SUB)) begin
						card_io_en <= 1'b0;
					end
					if (sub == 9'(`RST_LOW_SUB + `VCC_RAMP_SUB)) begin
						vcc_on <= 1'b0;
						vcc_ramp_down <= 1'b1;
					end
					if (at_ground) begin
						vcc_ramp_down <= 1'b0;
						converter_on <= 1'b0;
						contacts_grounded <= 1'b1;
						seq_busy <= 1'b0;
						state <= ST_OFF;
					end
				end
				default: state <= ST_OFF;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			card_ok_q <= 1'b0;
			card_ok <= 1'b0;
			presence_change_flag <= 1'b0;
		end else begin
			card_ok_q <= next_card_ok;
			card_ok <= next_card_ok;
			// Change wins over a read in the same cycle
			presence_change_flag <= (next_card_ok != card_ok_q) || (presence_change_flag && !status_read);
		end
	end
	wire [1:0] host_in = {aux_port_b_in, aux_port_a_in};
	wire [1:0] host_out;
	wire [1:0] host_oe_n;
	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_aux
			aux_repeater #(.DELAY_CYCLES(REP_DELAY_CYCLES)) u_rep (
				.clk(clk),
				.reset(reset),
				.host_in(host_in[i]),
				.host_out(host_out[i]),
				.host_oe_n(host_oe_n[i]),
				.card_in(aux_card_in[i]),
				.card_out(aux_card_out[i]),
				.card_oe_n(aux_card_oe_n[i])
			);
		end
	endgenerate
	assign aux_port_a_out = host_out[0];
	assign aux_port_a_oe_n = host_oe_n[0];
	assign aux_port_b_out = host_out[1];
	assign aux_port_b_oe_n = host_oe_n[1];
	chk_rst_before_clk: assert property (@(posedge clk) disable iff (reset)
		$fell(card_clk_en) |-> !card_rst) else $error("clock stopped before reset low");
	chk_io_after_clk: assert property (@(posedge clk) disable iff (reset)
		$fell(card_io_en) |-> !card_clk_en && vcc_on) else $error("io low out of order");
	chk_deact_starts: assert property (@(posedge clk) disable iff (reset)
		(state == ST_ACTIVE && cmd_fall) |=> state == ST_WAIT_RST) else $error("deactivation not started");
	chk_fault_irq: assert property (@(posedge clk) disable iff (reset)
		(state == ST_ACTIVE && fault_now) |=> fault_irq && seq_busy) else $error("fault not flagged");
	chk_ground_end: assert property (@(posedge clk) disable iff (reset)
		$rose(contacts_grounded) |-> !vcc_on && !converter_on && !card_io_en) else $error("ground early");
	chk_no_early_act: assert property (@(posedge clk) disable iff (reset)
		seq_busy |=> !(state == ST_ACTIVE)) else $error("activation during deactivation");
	chk_change_flag: assert property (@(posedge clk) disable iff (reset)
		$changed(card_ok) |-> presence_change_flag) else $error("change flag missed");
	chk_absent_low: assert property (@(posedge clk) disable iff (reset)
		!card_present |=> !card_ok) else $error("card ok while absent");
	chk_vcc_last: assert property (@(posedge clk) disable iff (reset)
		$fell(vcc_on) |-> !card_io_en && !card_clk_en && !card_rst) else $error("supply dropped out of order");
	chk_ramp_window: assert property (@(posedge clk) disable iff (reset)
		vcc_ramp_down |-> !vcc_on && converter_on) else $error("ramp outside deactivation");
	// Held low for the whole sequence, even if the card comes back mid-way
	chk_fault_ok_low: assert property (@(posedge clk) disable iff (reset)
		(fault_pending && state != ST_OFF) |=> !card_ok) else $error("card ok during fault sequence");
	chk_removal_low: assert property (@(posedge clk) disable iff (reset)
		removed |-> !card_ok) else $error("card ok after removal");
	chk_flag_clear: assert property (@(posedge clk) disable iff (reset)
		(status_read && next_card_ok == card_ok_q) |=> !presence_change_flag) else $error("flag not cleared by read");
	cov_cmd_deact: cover property (@(posedge clk) disable iff (reset) cmd_fall ##[1:1000] seq_busy);
	cov_fault: cover property (@(posedge clk) disable iff (reset) $rose(fault_irq));
	cov_ok_back: cover property (@(posedge clk) disable iff (reset) fault_pending ##1 !fault_pending);
endmodule

//--- verification/card_contact_model.sv
// Card side of the two auxiliary contacts: pull-ups and card pull-downs.
// Assumes the bench says when the card pulls a contact low.
`timescale 1ns/1ps
module card_contact_model (
	input wire logic [1:0] card_oe_n,
	input wire logic [1:0] card_out,
	input wire logic [1:0] pull_low,
	output logic [1:0] card_wire
);
	// Undriven contact floats up to the card supply; either party may pull low
	assign card_wire = (card_oe_n | card_out) & ~pull_low;
endmodule

//--- verification/tb_card_deactivation_sequencer.sv
// Bench for the card sequencer: command and fault deactivation, flags, repeaters.
// Assumes short counts (4-cycle subtick, 3-cycle repeater delay).
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin failures++; $display("MISMATCH %0t %s", $time, m); end end
module tb_card_deactivation_sequencer;
	localparam int S = 4;
	localparam int RD = 3;
	logic clk = 0, reset = 1, card_present = 1, fault_overcurrent = 0, fault_short = 0, status_read = 0;
	logic [3:0] output_extension_register = 4'h0;
	logic card_rst, card_clk_en, card_io_en, vcc_on, vcc_ramp_down, converter_on, contacts_grounded;
	logic card_ok, presence_change_flag, fault_irq, seq_busy;
	logic [1:0] host_low = 2'h0, card_low = 2'h0, hout, hoe_n, card_out, card_oe_n, card_wire, host_wire;
	int failures = 0, n_compared = 0, cyc = 0;
	int offs[5] = '{0, 32, 64, 96, 320};
	always #4 clk = ~clk;
	always @(posedge clk) cyc++;
	// Controller ports are pulled up too; the bench pulls them low as the host
	assign host_wire = (hoe_n | hout) & ~host_low;
	card_deactivation_sequencer #(.SUBTICK_CYCLES(S), .REP_DELAY_CYCLES(RD)) card_deactivation_sequencer_i (
		.clk(clk), .reset(reset), .output_extension_register(output_extension_register),
		.card_present(card_present), .fault_overcurrent(fault_overcurrent), .fault_short(fault_short),
		.status_read(status_read), .card_rst(card_rst), .card_clk_en(card_clk_en), .card_io_en(card_io_en),
		.vcc_on(vcc_on), .vcc_ramp_down(vcc_ramp_down), .converter_on(converter_on),
		.contacts_grounded(contacts_grounded), .card_ok(card_ok), .presence_change_flag(presence_change_flag),
		.fault_irq(fault_irq), .seq_busy(seq_busy), .aux_port_a_in(host_wire[0]), .aux_port_a_out(hout[0]),
		.aux_port_a_oe_n(hoe_n[0]), .aux_port_b_in(host_wire[1]), .aux_port_b_out(hout[1]),
		.aux_port_b_oe_n(hoe_n[1]), .aux_card_in(card_wire), .aux_card_out(card_out), .aux_card_oe_n(card_oe_n));
	card_contact_model card_contact_model_i (.card_oe_n(card_oe_n), .card_out(card_out), .pull_low(card_low),
		.card_wire(card_wire));
	function automatic logic [4:0] sigv();
		return {~contacts_grounded, vcc_on, card_io_en, card_clk_en, card_rst};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic activate;
		int i;
		@(posedge clk) output_extension_register <= 4'h1;
		#1;
		for (i = 0; i < 50 && vcc_on !== 1'b1; i++) tick(1);
		`CHK(contacts_grounded, 1'b0, "card not powered")
	endtask
	task automatic clear_status;
		@(posedge clk) status_read <= 1'b1;
		@(posedge clk) status_read <= 1'b0;
		tick(1);
		`CHK(presence_change_flag, 1'b0, "flag not cleared")
	endtask
	// Walks the five steps; poke raises the command again once reset is low
	task automatic run_deact(input bit by_cmd, input bit poke);
		int t[5];
		int k, i, t0;
		if (by_cmd) @(posedge clk) output_extension_register <= 4'h0;
		#1 t0 = cyc;
		tick(1);
		`CHK(seq_busy, 1'b1, "not busy")
		for (k = 0; k < 5; k++) begin
			for (i = 0; i < 2000 && sigv() & (5'h1 << k); i++) tick(1);
			t[k] = cyc;
			if (k == 3) `CHK(vcc_ramp_down, 1'b1, "no supply ramp")
			if (k == 0 && poke) @(posedge clk) output_extension_register <= 4'h1;
		end
		if (by_cmd) `CHK(t[0] - t0 <= 2 * S + 2, 1'b1, "reset step late")
		for (k = 1; k < 5; k++) `CHK((t[k] - t[0] + S / 2) / S, offs[k], "step time")
		tick(8);
		`CHK({converter_on, seq_busy, contacts_grounded}, 3'b001, "not grounded idle")
	endtask
	task automatic t_fault(input bit short_kind);
		clear_status();
		activate();
		@(posedge clk) begin
			fault_overcurrent <= !short_kind;
			fault_short <= short_kind;
		end
		tick(1);
		`CHK(fault_irq, 1'b1, "no fault interrupt")
		@(posedge clk) {fault_overcurrent, fault_short} <= 2'b00;
		tick(1);
		`CHK(card_ok, 1'b0, "ok kept in fault")
		`CHK(presence_change_flag, 1'b1, "no change flag")
		run_deact(0, 0);
		`CHK(card_ok, 1'b0, "ok before command low")
		@(posedge clk) output_extension_register <= 4'h0;
		tick(3);
		`CHK(card_ok, 1'b1, "ok not back")
		$display("fault test done");
	endtask
	task automatic t_remove;
		activate();
		@(posedge clk) card_present <= 1'b0;
		run_deact(0, 0);
		@(posedge clk) output_extension_register <= 4'h0;
		tick(5);
		`CHK(card_ok, 1'b0, "ok without card")
		@(posedge clk) card_present <= 1'b1;
		tick(3);
		`CHK(card_ok, 1'b1, "ok after insert")
		$display("removal test done");
	endtask
	task automatic rep(input int m, input bit from_host);
		int i;
		@(posedge clk) if (from_host) host_low[m] <= 1'b1; else card_low[m] <= 1'b1;
		#1;
		for (i = 0; i < 20 && (from_host ? card_oe_n[m] : hoe_n[m]) !== 1'b0; i++) tick(1);
		`CHK(i >= RD && i <= RD + 2, 1'b1, "slave pull delay")
		`CHK(from_host ? card_wire[m] : host_wire[m], 1'b0, "slave not low")
		`CHK(from_host ? hoe_n[m] : card_oe_n[m], 1'b1, "master side driven")
		tick(130);
		@(posedge clk) if (from_host) host_low[m] <= 1'b0; else card_low[m] <= 1'b0;
		tick(2);
		`CHK(from_host ? {card_oe_n[m], card_out[m]} : {hoe_n[m], hout[m]}, 2'b01, "slave not driven high")
		tick(RD + 3);
		`CHK({hoe_n[m], card_oe_n[m]}, 2'b11, "not idle")
		tick(130);
		$display("repeater test done");
	endtask
	task automatic summarize;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		failures++;
		$display("MISMATCH %0t watchdog expired", $time);
		summarize();
	end
	initial begin
		tick(4);
		@(posedge clk) reset <= 1'b0;
		tick(3);
		`CHK({contacts_grounded, card_ok}, 2'b11, "idle state")
		activate();
		run_deact(1, 0);
		activate();
		run_deact(1, 1);
		@(posedge clk) output_extension_register <= 4'h0;
		$display("command test done");
		t_fault(0);
		t_fault(1);
		t_remove();
		rep(0, 1);
		rep(1, 0);
		rep(0, 0);
		rep(1, 1);
		summarize();
	end
endmodule
